// ### src/filt_cfg_pkg.sv
// package: register map, field layout and types of the acceptance filter configuration bank
package filt_cfg_pkg;

  // ****************************************************************
  // register offsets (byte addresses)
  // ****************************************************************
  localparam logic [7:0] OFS_LINE_EN = 8'h5C;
  localparam logic [7:0] OFS_GLOBAL = 8'h80;
  localparam logic [7:0] OFS_STD_CFG = 8'h84;
  localparam logic [7:0] OFS_EXT_CFG = 8'h88;
  localparam logic [7:0] OFS_EXT_MASK = 8'h90;
  localparam logic [7:0] OFS_PRIO_STAT = 8'h94;
  localparam logic [7:0] OFS_EVT_STAT = 8'hE0;
  localparam logic [7:0] OFS_EVT_CLR = 8'hE4;
  localparam logic [7:0] OFS_EVT_EN = 8'hE8;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int LINE1_BIT = 1;
  localparam int LINE0_BIT = 0;
  localparam int NM_STD_LO = 4;
  localparam int NM_EXT_LO = 2;
  localparam int REJ_STD_BIT = 1;
  localparam int REJ_EXT_BIT = 0;
  localparam int SIZE_LO = 16;
  localparam int START_LO = 2;
  localparam int LST_BIT = 15;
  localparam int MATCH_FILTER_INDEX_LO = 8;
  localparam int MSI_LO = 6;
  localparam int FIFO_ELEMENT_INDEX_LO = 0;

  // ****************************************************************
  // limits and reset values
  // ****************************************************************
  localparam logic [7:0] STD_SIZE_MAX = 8'h80;
  localparam logic [6:0] EXT_SIZE_MAX = 7'h40;
  localparam logic [28:0] EXT_MASK_RST = 29'h1FFFFFFF;
  localparam logic [13:0] START_RST = 14'h0000;
  localparam logic [1:0] ROUTE_RST = 2'h0;
  localparam int EVT_W = 2;

  // routing of frames that match no filter element
  typedef enum logic [1:0] {
    ROUTE_FIFO0 = 2'h0,
    ROUTE_FIFO1 = 2'h1,
    ROUTE_REJ_A = 2'h2,
    ROUTE_REJ_B = 2'h3
  } route_e;

  // storage indicator encoding
  typedef enum logic [1:0] {
    MSI_NONE = 2'h0,
    MSI_LOST = 2'h1,
    MSI_FIFO0 = 2'h2,
    MSI_FIFO1 = 2'h3
  } msi_e;

  // priority match report from the filter engine
  typedef struct packed {
    logic list_ext;
    logic [6:0] filter_idx;
    msi_e storage;
    logic [5:0] fifo_idx;
  } prio_match_s;

  // configuration presented to the filter engine
  typedef struct packed {
    route_e nonmatch_std_route;
    route_e nonmatch_ext_route;
    logic reject_remote_std;
    logic reject_remote_ext;
    logic [7:0] std_list_size;
    logic [13:0] std_list_start;
    logic [6:0] ext_list_size;
    logic [13:0] ext_list_start;
    logic [28:0] ext_id_mask;
  } filt_cfg_s;

endpackage

// ### src/can_acceptance_filter_config.sv
// acceptance filter configuration and priority status register bank of a can controller
`timescale 1ns/100ps
// ****************************************************************
// Summary of operation
// - line1_enable bit 1 gates interrupt line 1
// - line0_enable bit 0 gates interrupt line 0
// - bits 5:4 route unmatched standard frames
// - bits 3:2 route unmatched extended frames
// - bit 1 rejects standard remote frames
// - bit 0 rejects extended remote frames
// - standard list size, reads back as written, above 128 the engine gets 128
// - standard list start word address bits 15:2
// - extended list size, reads back as written, above 64 the engine gets 64
// - extended list start word address bits 15:2
// - received extended id ANDed with mask
// - mask resets to all ones
// - priority status updated on every priority match
// - bit 15 tells standard or extended list
// - bits 14:8 hold matching filter index
// - bits 7:6 tell where message went
// - bits 5:0 fifo element index
// ****************************************************************
module can_acceptance_filter_config
  import filt_cfg_pkg::*;
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // register port
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  // interrupt sources from the controller core
  input wire logic i_irq_src_0,
  input wire logic i_irq_src_1,
  output logic o_irq_line_0,
  output logic o_irq_line_1,
  // priority match report from the filter engine
  input wire logic i_prio_match,
  input wire prio_match_s i_prio_info,
  // received extended id to be masked
  input wire logic [28:0] i_rx_ext_id,
  output logic [28:0] o_masked_ext_id,
  // configuration to the filter engine
  output filt_cfg_s o_cfg,
  // frame classification helpers
  output logic o_std_filter_on,
  output logic o_ext_filter_on,
  // block event interrupt
  output logic o_irq
);

  // ****************************************************************
  // storage
  // ****************************************************************
  logic line0_enable_ff;
  logic line1_enable_ff;
  route_e nonmatch_std_route_ff;
  route_e nonmatch_ext_route_ff;
  logic reject_remote_std_ff;
  logic reject_remote_ext_ff;
  logic [7:0] std_list_size_ff;
  logic [13:0] std_list_start_ff;
  logic [6:0] ext_list_size_ff;
  logic [13:0] ext_list_start_ff;
  logic [28:0] ext_id_mask_ff;
  prio_match_s prio_stat_ff;
  logic [EVT_W-1:0] evt_stat_ff;
  logic [EVT_W-1:0] evt_en_ff;
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;
  logic [EVT_W-1:0] evt_set;
  logic [7:0] std_size_eff;
  logic [6:0] ext_size_eff;

  // write decode helpers
  logic wr_line_en;
  logic wr_global;
  logic wr_std;
  logic wr_ext;
  logic wr_mask;
  logic wr_evt_clr;
  logic wr_evt_en;

  assign wr_line_en = i_wr && (i_addr == OFS_LINE_EN);
  assign wr_global = i_wr && (i_addr == OFS_GLOBAL);
  assign wr_std = i_wr && (i_addr == OFS_STD_CFG);
  assign wr_ext = i_wr && (i_addr == OFS_EXT_CFG);
  assign wr_mask = i_wr && (i_addr == OFS_EXT_MASK);
  assign wr_evt_clr = i_wr && (i_addr == OFS_EVT_CLR);
  assign wr_evt_en = i_wr && (i_addr == OFS_EVT_EN);

  // ****************************************************************
  // interrupt line enables
  // ****************************************************************
  // only bits 1:0 are stored, upper bits are dropped
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      line0_enable_ff <= 1'b0;
      line1_enable_ff <= 1'b0;
    end else if (wr_line_en) begin
      line0_enable_ff <= i_wdata[LINE0_BIT];
      line1_enable_ff <= i_wdata[LINE1_BIT];
    end
  end

  // gating is combinational so a disable takes effect at once
  assign o_irq_line_0 = i_irq_src_0 && line0_enable_ff;
  assign o_irq_line_1 = i_irq_src_1 && line1_enable_ff;

  // ****************************************************************
  // global filter configuration
  // ****************************************************************
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      nonmatch_std_route_ff <= route_e'(ROUTE_RST);
      nonmatch_ext_route_ff <= route_e'(ROUTE_RST);
      reject_remote_std_ff <= 1'b0;
      reject_remote_ext_ff <= 1'b0;
    end else if (wr_global) begin
      nonmatch_std_route_ff <= route_e'(i_wdata[NM_STD_LO +: 2]);
      nonmatch_ext_route_ff <= route_e'(i_wdata[NM_EXT_LO +: 2]);
      reject_remote_std_ff <= i_wdata[REJ_STD_BIT];
      reject_remote_ext_ff <= i_wdata[REJ_EXT_BIT];
    end
  end

  // ****************************************************************
  // filter list configuration
  // ****************************************************************
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      std_list_size_ff <= 8'h00;
      std_list_start_ff <= START_RST;
    end else if (wr_std) begin
      std_list_size_ff <= i_wdata[SIZE_LO +: 8];
      std_list_start_ff <= i_wdata[START_LO +: 14];
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      ext_list_size_ff <= 7'h00;
      ext_list_start_ff <= START_RST;
    end else if (wr_ext) begin
      ext_list_size_ff <= i_wdata[SIZE_LO +: 7];
      ext_list_start_ff <= i_wdata[START_LO +: 14];
    end
  end

  // the written value reads back as stored; the clamp applies to what the engine uses
  assign std_size_eff = (std_list_size_ff > STD_SIZE_MAX) ? STD_SIZE_MAX : std_list_size_ff;
  assign ext_size_eff = (ext_list_size_ff > EXT_SIZE_MAX) ? EXT_SIZE_MAX : ext_list_size_ff;
  assign o_std_filter_on = (std_list_size_ff != 8'h00);
  assign o_ext_filter_on = (ext_list_size_ff != 7'h00);

  // ****************************************************************
  // extended id mask
  // ****************************************************************
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      ext_id_mask_ff <= EXT_MASK_RST;
    end else if (wr_mask) begin
      ext_id_mask_ff <= i_wdata[28:0];
    end
  end

  assign o_masked_ext_id = i_rx_ext_id & ext_id_mask_ff;

  // configuration bundle to the engine
  always_comb begin
    o_cfg.nonmatch_std_route = nonmatch_std_route_ff;
    o_cfg.nonmatch_ext_route = nonmatch_ext_route_ff;
    o_cfg.reject_remote_std = reject_remote_std_ff;
    o_cfg.reject_remote_ext = reject_remote_ext_ff;
    o_cfg.std_list_size = std_size_eff;
    o_cfg.std_list_start = std_list_start_ff;
    o_cfg.ext_list_size = ext_size_eff;
    o_cfg.ext_list_start = ext_list_start_ff;
    o_cfg.ext_id_mask = ext_id_mask_ff;
  end

  // ****************************************************************
  // priority message status
  // ****************************************************************
  // read only; the latest priority match overwrites the previous one
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      prio_stat_ff <= '0;
    end else if (i_prio_match) begin
      prio_stat_ff <= i_prio_info;
    end
  end

  // ****************************************************************
  // event status, clear and enable
  // ****************************************************************
  // bit 0: priority match, bit 1: priority message lost
  assign evt_set = {i_prio_match && (i_prio_info.storage == MSI_LOST), i_prio_match};

  // set wins over a clear in the same cycle so no event is lost
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      evt_stat_ff <= '0;
    end else begin
      evt_stat_ff <= (evt_stat_ff & ~(wr_evt_clr ? i_wdata[EVT_W-1:0] : '0)) | evt_set;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      evt_en_ff <= '0;
    end else if (wr_evt_en) begin
      evt_en_ff <= i_wdata[EVT_W-1:0];
    end
  end

  assign o_irq = |(evt_stat_ff & evt_en_ff);

  // ****************************************************************
  // read path
  // ****************************************************************
  // unmapped and write-only addresses read zero
  always_comb begin
    nxt_rdata = 32'h00000000;
    if (i_rd) begin
      unique case (i_addr)
        OFS_LINE_EN: nxt_rdata = {30'h0, line1_enable_ff, line0_enable_ff};
        OFS_GLOBAL: nxt_rdata = {26'h0, nonmatch_std_route_ff, nonmatch_ext_route_ff,
                                 reject_remote_std_ff, reject_remote_ext_ff};
        OFS_STD_CFG: nxt_rdata = {8'h0, std_list_size_ff, std_list_start_ff, 2'h0};
        OFS_EXT_CFG: nxt_rdata = {9'h0, ext_list_size_ff, ext_list_start_ff, 2'h0};
        OFS_EXT_MASK: nxt_rdata = {3'h0, ext_id_mask_ff};
        OFS_PRIO_STAT: nxt_rdata = {16'h0, prio_stat_ff};
        OFS_EVT_STAT: nxt_rdata = {30'h0, evt_stat_ff};
        OFS_EVT_EN: nxt_rdata = {30'h0, evt_en_ff};
        default: nxt_rdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      rdata_ff <= 32'h00000000;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign o_rdata = rdata_ff;

  // ****************************************************************
  // checks
  // ****************************************************************
  chk_line0_gate: assert property (@(posedge i_clk) disable iff (i_rst)
    !line0_enable_ff |-> !o_irq_line_0) else $error("line 0 active while disabled");

  chk_line1_gate: assert property (@(posedge i_clk) disable iff (i_rst)
    (line1_enable_ff && i_irq_src_1) == o_irq_line_1) else $error("line 1 gating wrong");

  chk_line_write: assert property (@(posedge i_clk) disable iff (i_rst)
    wr_line_en |=> line1_enable_ff == $past(i_wdata[1])) else $error("line enable not stored");

  chk_global_route: assert property (@(posedge i_clk) disable iff (i_rst)
    wr_global |=> (o_cfg.nonmatch_std_route == $past(i_wdata[5:4]))
      && (o_cfg.nonmatch_ext_route == $past(i_wdata[3:2]))) else $error("route field wrong");

  chk_remote_rej: assert property (@(posedge i_clk) disable iff (i_rst)
    wr_global |=> o_cfg.reject_remote_std == $past(i_wdata[1])
      && o_cfg.reject_remote_ext == $past(i_wdata[0])) else $error("remote reject bit wrong");

  chk_std_clamp: assert property (@(posedge i_clk) disable iff (i_rst)
    (std_list_size_ff > 8'h80) ? (o_cfg.std_list_size == 8'h80) : (o_cfg.std_list_size == std_list_size_ff))
    else $error("standard size clamp wrong");

  chk_ext_clamp: assert property (@(posedge i_clk) disable iff (i_rst)
    (ext_list_size_ff > 7'h40) ? (o_cfg.ext_list_size == 7'h40) : (o_cfg.ext_list_size == ext_list_size_ff))
    else $error("extended size clamp wrong");

  chk_mask_and: assert property (@(posedge i_clk) disable iff (i_rst)
    o_masked_ext_id == (i_rx_ext_id & ext_id_mask_ff)) else $error("mask not applied");

  chk_mask_reset: assert property (@(posedge i_clk)
    $fell(i_rst) |-> ext_id_mask_ff == 29'h1FFFFFFF) else $error("mask reset value wrong");

  chk_prio_update: assert property (@(posedge i_clk) disable iff (i_rst)
    i_prio_match ##1 !i_prio_match ##1 (i_rd && i_addr == 8'h94)
      |=> o_rdata[15:0] == $past(i_prio_info, 3))
    else $error("priority status not updated");

  chk_prio_hold: assert property (@(posedge i_clk) disable iff (i_rst)
    !i_prio_match |=> $stable(prio_stat_ff)) else $error("priority status changed without match");

  chk_reserved_zero: assert property (@(posedge i_clk) disable iff (i_rst)
    $past(i_rd) && $past(i_addr) == 8'h84 |-> o_rdata[31:24] == 8'h00 && o_rdata[1:0] == 2'h0)
    else $error("reserved bits not zero");

  // ****************************************************************
  // checks: enables, list settings and mask as stored
  // ****************************************************************
  // line 0 is checked both ways; a gate stuck low would pass chk_line0_gate alone
  chk_line0_write: assert property (@(posedge i_clk) disable iff (i_rst)
    wr_line_en |=> line0_enable_ff == $past(i_wdata[0]))
    else $error("line 0 enable not stored");

  chk_line0_pass: assert property (@(posedge i_clk) disable iff (i_rst)
    line0_enable_ff && i_irq_src_0 |-> o_irq_line_0)
    else $error("line 0 blocked while enabled");

  // the raw size is kept as written; only the engine copy is clamped
  chk_std_size_keep: assert property (@(posedge i_clk) disable iff (i_rst)
    wr_std |=> std_list_size_ff == $past(i_wdata[23:16]))
    else $error("standard size not stored");

  chk_std_start: assert property (@(posedge i_clk) disable iff (i_rst)
    wr_std |=> o_cfg.std_list_start == $past(i_wdata[15:2]))
    else $error("standard start not stored");

  chk_ext_size_keep: assert property (@(posedge i_clk) disable iff (i_rst)
    wr_ext |=> ext_list_size_ff == $past(i_wdata[22:16]))
    else $error("extended size not stored");

  chk_ext_start: assert property (@(posedge i_clk) disable iff (i_rst)
    wr_ext |=> o_cfg.ext_list_start == $past(i_wdata[15:2]))
    else $error("extended start not stored");

  chk_mask_write: assert property (@(posedge i_clk) disable iff (i_rst)
    wr_mask |=> o_cfg.ext_id_mask == $past(i_wdata[28:0]))
    else $error("mask not stored");

  // ****************************************************************
  // checks: priority status, events and read path
  // ****************************************************************
  // a priority match must land whole, whatever the status held before
  chk_prio_capture: assert property (@(posedge i_clk) disable iff (i_rst)
    i_prio_match |=> prio_stat_ff == $past(i_prio_info))
    else $error("priority match not captured");

  chk_prio_fields: assert property (@(posedge i_clk) disable iff (i_rst)
    i_rd && i_addr == 8'h94 |=> o_rdata[31:16] == 16'h0000
      && o_rdata[15] == $past(prio_stat_ff.list_ext)
      && o_rdata[14:8] == $past(prio_stat_ff.filter_idx)
      && o_rdata[7:6] == $past(prio_stat_ff.storage)
      && o_rdata[5:0] == $past(prio_stat_ff.fifo_idx))
    else $error("priority status fields misplaced");

  // set beats clear, otherwise a match in the clear cycle would vanish unseen
  chk_evt_set_wins: assert property (@(posedge i_clk) disable iff (i_rst)
    (|evt_set) |=> (evt_stat_ff & $past(evt_set)) == $past(evt_set))
    else $error("event lost to a clear");

  chk_evt_clear: assert property (@(posedge i_clk) disable iff (i_rst)
    wr_evt_clr && !(|evt_set) |=> (evt_stat_ff & $past(i_wdata[1:0])) == 2'h0)
    else $error("event not cleared");

  // read data stand one cycle only, so a stale word is never taken for a fresh one
  chk_rdata_idle: assert property (@(posedge i_clk) disable iff (i_rst)
    !i_rd |=> o_rdata == 32'h00000000)
    else $error("read data outside read cycle");

  chk_line_reserved: assert property (@(posedge i_clk) disable iff (i_rst)
    $past(i_rd) && $past(i_addr) == 8'h5C |-> o_rdata[31:2] == 30'h0)
    else $error("line enable reserved bits not zero");

  chk_global_reserved: assert property (@(posedge i_clk) disable iff (i_rst)
    $past(i_rd) && $past(i_addr) == 8'h80 |-> o_rdata[31:6] == 26'h0)
    else $error("global reserved bits not zero");

  chk_ext_reserved: assert property (@(posedge i_clk) disable iff (i_rst)
    $past(i_rd) && $past(i_addr) == 8'h88 |-> o_rdata[31:23] == 9'h0 && o_rdata[1:0] == 2'h0)
    else $error("extended reserved bits not zero");

endmodule

// ### verification/tb.sv
// testbench: self-checking scenarios for the acceptance filter configuration bank
`timescale 1ns/100ps
module tb
  import filt_cfg_pkg::*;
;
  // ****************************************************************
  // stimulus and observed signals
  // ****************************************************************
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic [7:0] i_addr = 8'h00;
  logic [31:0] i_wdata = 32'h0;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic i_irq_src_0 = 1'b0;
  logic i_irq_src_1 = 1'b0;
  logic i_prio_match = 1'b0;
  prio_match_s i_prio_info = '0;
  logic [28:0] i_rx_ext_id = 29'h1ABCDEF5;
  logic [31:0] o_rdata;
  logic o_irq_line_0;
  logic o_irq_line_1;
  logic [28:0] o_masked_ext_id;
  filt_cfg_s o_cfg;
  logic o_std_filter_on;
  logic o_ext_filter_on;
  logic o_irq;
  int failures = 0;
  int tests_run = 0;

  always #5 i_clk = ~i_clk;

  can_acceptance_filter_config u_can_acceptance_filter_config (
    .i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .o_rdata(o_rdata), .i_irq_src_0(i_irq_src_0), .i_irq_src_1(i_irq_src_1),
    .o_irq_line_0(o_irq_line_0), .o_irq_line_1(o_irq_line_1), .i_prio_match(i_prio_match),
    .i_prio_info(i_prio_info), .i_rx_ext_id(i_rx_ext_id), .o_masked_ext_id(o_masked_ext_id),
    .o_cfg(o_cfg), .o_std_filter_on(o_std_filter_on), .o_ext_filter_on(o_ext_filter_on), .o_irq(o_irq)
  );

  // ****************************************************************
  // shared tasks
  // ****************************************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d, mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // a strobe lasts one cycle; the next task waits for a fresh edge before raising one
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe, so sample just past that edge
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string msg);
    @(posedge i_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1;
    check(o_rdata, exp, msg);
  endtask

  task automatic do_reset();
    @(posedge i_clk);
    i_rst <= 1'b1;
    repeat (2) @(posedge i_clk);
    i_rst <= 1'b0;
    @(posedge i_clk);
  endtask

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic test_reset_values();
    rd_chk(OFS_LINE_EN, 32'h0, "line enable reset");
    rd_chk(OFS_GLOBAL, 32'h0, "global reset");
    rd_chk(OFS_STD_CFG, 32'h0, "std cfg reset");
    rd_chk(OFS_EXT_CFG, 32'h0, "ext cfg reset");
    rd_chk(OFS_EXT_MASK, 32'h1FFFFFFF, "mask reset");
    rd_chk(OFS_PRIO_STAT, 32'h0, "prio status reset");
    check({3'h0, o_masked_ext_id}, {3'h0, i_rx_ext_id}, "mask passes id");
  endtask

  task automatic test_line_enable();
    logic [1:0] e;
    @(posedge i_clk);
    i_irq_src_0 <= 1'b1;
    i_irq_src_1 <= 1'b1;
    for (int k = 0; k < 4; k++) begin
      e = 2'(k);
      wr(OFS_LINE_EN, {30'h3FFFFFFF, e});
      rd_chk(OFS_LINE_EN, {30'h0, e}, "line enable readback");
      check({31'h0, o_irq_line_0}, {31'h0, e[0]}, "line 0 gate");
      check({31'h0, o_irq_line_1}, {31'h0, e[1]}, "line 1 gate");
    end
    @(posedge i_clk);
    i_irq_src_0 <= 1'b0;
    #1;
    check({31'h0, o_irq_line_0}, 32'h0, "line 0 follows source");
  endtask

  task automatic test_global();
    logic [1:0] r;
    for (int k = 0; k < 4; k++) begin
      r = 2'(k);
      wr(OFS_GLOBAL, {26'h3FFFFFF, r, ~r, r});
      rd_chk(OFS_GLOBAL, {26'h0, r, ~r, r}, "global readback");
      check({30'h0, o_cfg.nonmatch_std_route}, {30'h0, r}, "std route");
      check({30'h0, o_cfg.nonmatch_ext_route}, {30'h0, ~r}, "ext route");
      check({31'h0, o_cfg.reject_remote_std}, {31'h0, r[1]}, "reject std");
      check({31'h0, o_cfg.reject_remote_ext}, {31'h0, r[0]}, "reject ext");
    end
  endtask

  // boundary sizes on both sides of the clamp, with reserved bits written as ones
  task automatic test_lists();
    logic [7:0] ss[5] = '{8'h00, 8'h01, 8'h80, 8'h81, 8'hFF};
    logic [6:0] es[5] = '{7'h00, 7'h01, 7'h40, 7'h41, 7'h7F};
    logic [13:0] st;
    for (int k = 0; k < 5; k++) begin
      st = {ss[k], 6'h2A};
      wr(OFS_STD_CFG, {8'hFF, ss[k], st, 2'h3});
      rd_chk(OFS_STD_CFG, {8'h00, ss[k], st, 2'h0}, "std cfg readback");
      check({24'h0, o_cfg.std_list_size}, {24'h0, (ss[k] > 8'h80) ? 8'h80 : ss[k]}, "std size");
      check({18'h0, o_cfg.std_list_start}, {18'h0, st}, "std start");
      check({31'h0, o_std_filter_on}, {31'h0, ss[k] != 8'h00}, "std filter on");
      st = {es[k], 7'h55};
      wr(OFS_EXT_CFG, {9'h1FF, es[k], st, 2'h3});
      rd_chk(OFS_EXT_CFG, {9'h0, es[k], st, 2'h0}, "ext cfg readback");
      check({25'h0, o_cfg.ext_list_size}, {25'h0, (es[k] > 7'h40) ? 7'h40 : es[k]}, "ext size");
      check({18'h0, o_cfg.ext_list_start}, {18'h0, st}, "ext start");
      check({31'h0, o_ext_filter_on}, {31'h0, es[k] != 7'h00}, "ext filter on");
    end
  endtask

  task automatic test_mask();
    wr(OFS_EXT_MASK, 32'hF0F0F0F0);
    rd_chk(OFS_EXT_MASK, 32'h10F0F0F0, "mask readback");
    @(posedge i_clk);
    i_rx_ext_id <= 29'h0F0F1234;
    #1;
    check({3'h0, o_masked_ext_id}, {3'h0, 29'h0F0F1234 & 29'h10F0F0F0}, "masked id");
    check({3'h0, o_cfg.ext_id_mask}, 32'h10F0F0F0, "mask to engine");
  endtask

  task automatic prio_pulse(input logic [15:0] info);
    @(posedge i_clk);
    i_prio_match <= 1'b1;
    i_prio_info <= prio_match_s'(info);
    @(posedge i_clk);
    i_prio_match <= 1'b0;
  endtask

  // two matches with one idle cycle between them: the later one wins, a lost message raises the second event
  task automatic test_priority();
    prio_pulse(16'hA5C3);
    rd_chk(OFS_PRIO_STAT, 32'h0000A5C3, "prio status");
    rd_chk(OFS_EVT_STAT, 32'h1, "event match only");
    check({31'h0, o_irq}, 32'h0, "irq masked");
    prio_pulse(16'h1282);
    prio_pulse(16'h2A7F);
    rd_chk(OFS_PRIO_STAT, 32'h00002A7F, "prio last wins");
    wr(OFS_PRIO_STAT, 32'h0);
    rd_chk(OFS_PRIO_STAT, 32'h00002A7F, "prio read only");
    rd_chk(OFS_EVT_STAT, 32'h3, "event lost set");
    wr(OFS_EVT_EN, 32'h3);
    #1;
    check({31'h0, o_irq}, 32'h1, "irq enabled");
    wr(OFS_EVT_CLR, 32'h1);
    rd_chk(OFS_EVT_STAT, 32'h2, "event clear one");
    check({31'h0, o_irq}, 32'h1, "irq still set");
    wr(OFS_EVT_CLR, 32'h2);
    rd_chk(OFS_EVT_STAT, 32'h0, "event clear all");
    check({31'h0, o_irq}, 32'h0, "irq dropped");
    rd_chk(OFS_EVT_CLR, 32'h0, "clear reads zero");
    wr(8'h60, 32'hFFFFFFFF);
    rd_chk(8'h60, 32'h0, "unmapped reads zero");
  endtask

  // reset in mid-run restores the reset values
  task automatic test_second_reset();
    do_reset();
    test_reset_values();
    rd_chk(OFS_EVT_EN, 32'h0, "event enable reset");
  endtask

  // ****************************************************************
  // main sequence and watchdog
  // ****************************************************************
  initial begin
    repeat (2) @(posedge i_clk);
    i_rst <= 1'b0;
    @(posedge i_clk);
    test_reset_values();
    test_line_enable();
    test_global();
    test_lists();
    test_mask();
    test_priority();
    test_second_reset();
    stop_test();
  end

  // the scenarios need about 150 cycles; allow far more before calling it a hang
  initial begin
    #50000;
    failures++;
    $display("mismatch at %0t: watchdog expired", $time);
    stop_test();
  end
endmodule
